// ### aicl_pkg.sv
/*
  aicl_pkg: shared constants and carrier types of the input configuration latch.
  Assumes a single 125 MHz clock domain; all pins arrive asynchronously.
*/
package aicl_pkg;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned CHAN_COUNT    = 6;
  localparam int unsigned PAIR_COUNT    = 3;
  localparam int unsigned RES_BITS      = 12;
  localparam int unsigned LSB_DIVISOR   = 4096;
  localparam logic [2:0]  ADDR_MAX_SGL  = 3'h5;
  localparam logic [1:0]  PAIR_MAX      = 2'h2;
  localparam logic        RST_SGL       = 1'h0;
  localparam logic [2:0]  RST_ADDR      = 3'h0;
  localparam logic        RST_RANGE     = 1'h0;
  localparam int unsigned ADDR_PAIR_POS = 1;
  localparam int unsigned ADDR_PSD_POS  = 0;

  typedef enum logic [1:0] {
    AICL_CODE_BINARY,
    AICL_CODE_TWOS
  } aicl_coding_t;

  typedef enum logic [1:0] {
    AICL_IN_SINGLE,
    AICL_IN_FULLDIFF,
    AICL_IN_PSEUDODIFF
  } aicl_intype_t;

  // pin levels captured together at one chip select falling edge
  typedef struct packed {
    logic       sgl;
    logic [2:0] addr;
    logic       range;
  } aicl_pins_t;

  // configuration applied to one conversion
  typedef struct packed {
    aicl_intype_t inType;
    logic [5:0]   posSel;
    logic [5:0]   negSel;
    logic         negGnd;
    logic         rangeDouble;
    aicl_coding_t coding;
    logic         addrLegal;
  } aicl_cfg_t;
endpackage

// ### aicl_sync.sv
/*
  aicl_sync: parameterised multi-stage synchroniser for asynchronous pins.
  Assumes the destination clock is clk; the first stage is read only by the second.
*/
`timescale 1ns/1ps
module aicl_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = aicl_pkg::SYNC_STAGES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] rstVal,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage_ff [STAGES];

  initial
  begin
    if (STAGES < 2) $error("aicl_sync needs at least two stages");
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < STAGES; i++) stage_ff[i] <= '0;
    end
    else
    begin
      stage_ff[0] <= asyncIn;
      for (int i = 1; i < STAGES; i++) stage_ff[i] <= stage_ff[i-1];
    end
  end

  assign syncOut = stage_ff[STAGES-1] ^ (rstVal & '0);
endmodule

// ### aicl_adc_input_config_latch.sv
/*
  aicl_adc_input_config_latch: samples input type, channel address and range
  pins at each chip select falling edge and applies them to the next conversion.
  Assumes the host drives the pins asynchronously to clk and holds them stable
  around the chip select falling edge for several clk periods.
*/
`timescale 1ns/1ps
module aicl_adc_input_config_latch #(
  parameter int unsigned RESOLUTION = aicl_pkg::RES_BITS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // host pins, asynchronous
  input  wire logic               chipSelect_n,
  input  wire logic               input_type_select,
  input  wire logic               chan_addr_bit0,
  input  wire logic               chan_addr_bit1,
  input  wire logic               chan_addr_bit2,
  input  wire logic               rangeSelect,
  // conversion in progress
  output logic                    convStart,
  output logic                    convActive,
  output aicl_pkg::aicl_cfg_t     activeCfg,
  // configuration latched for the next conversion
  output aicl_pkg::aicl_pins_t    pendingPins,
  // code step: LSB = vref / lsbDivisor
  output logic [RESOLUTION:0]     lsbDivisor
);
  initial
  begin
    if ((1 << RESOLUTION) != aicl_pkg::LSB_DIVISOR)
      $error("resolution must match the 4096 step divisor");
  end

  logic                 csSync;
  aicl_pkg::aicl_pins_t pinsSync;
  aicl_pkg::aicl_pins_t pinsRaw;
  aicl_pkg::aicl_pins_t pinsRst;
  logic                 csPrev_ff;
  aicl_pkg::aicl_pins_t pend_ff;
  aicl_pkg::aicl_cfg_t  act_ff;
  logic                 start_ff;
  logic                 active_ff;
  logic [RESOLUTION:0]  lsb_ff;
  aicl_pkg::aicl_cfg_t  nxt_cfg;
  logic                 csFall;
  logic                 csRise;

  assign pinsRaw = '{sgl: input_type_select,
                     addr: {chan_addr_bit2, chan_addr_bit1, chan_addr_bit0},
                     range: rangeSelect};
  assign pinsRst = '{sgl: aicl_pkg::RST_SGL, addr: aicl_pkg::RST_ADDR,
                     range: aicl_pkg::RST_RANGE};

  // select is synchronised active high so that the reset level of the stages is the idle
  // level; a high select at reset release can then never look like a falling edge
  aicl_sync #(.WIDTH(1)) u_cs_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (~chipSelect_n),
    .rstVal  (1'h0),
    .syncOut (csSync)
  );

  aicl_sync #(.WIDTH($bits(aicl_pkg::aicl_pins_t))) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (pinsRaw),
    .rstVal  (pinsRst),
    .syncOut (pinsSync)
  );

  // csSync is high while selected: its rise is the chip select falling edge
  assign csFall = ~csPrev_ff & csSync;
  assign csRise = csPrev_ff & ~csSync;

  // decode of the configuration latched at the previous edge
  logic       pendSgl;
  logic [1:0] pendPair;
  logic       pendPseudo;
  logic       pendSeLegal;
  logic       pendDiffLegal;
  logic [5:0] seOneHot;
  logic [5:0] pairPos;
  logic [5:0] pairNeg;

  assign pendSgl       = pend_ff.sgl;
  assign pendPair      = pend_ff.addr[2:aicl_pkg::ADDR_PAIR_POS];
  assign pendPseudo    = pend_ff.addr[aicl_pkg::ADDR_PSD_POS];
  assign pendSeLegal   = pend_ff.addr <= aicl_pkg::ADDR_MAX_SGL;
  assign pendDiffLegal = pendPair <= aicl_pkg::PAIR_MAX;
  assign seOneHot      = pendSeLegal ? (6'h01 << pend_ff.addr) : 6'h00;
  assign pairPos       = pendDiffLegal ? (6'h01 << {pendPair, 1'b0}) : 6'h00;
  assign pairNeg       = pendDiffLegal ? (6'h02 << {pendPair, 1'b0}) : 6'h00;

  always_comb
  begin
    nxt_cfg = '0;
    nxt_cfg.rangeDouble = pend_ff.range;
    if (pendSgl)
    begin
      nxt_cfg.inType    = aicl_pkg::AICL_IN_SINGLE;
      nxt_cfg.posSel    = seOneHot;
      nxt_cfg.negSel    = 6'h00;
      nxt_cfg.negGnd    = 1'b1;
      nxt_cfg.addrLegal = pendSeLegal;
    end
    else
    begin
      nxt_cfg.inType    = pendPseudo ? aicl_pkg::AICL_IN_PSEUDODIFF
                                     : aicl_pkg::AICL_IN_FULLDIFF;
      nxt_cfg.posSel    = pairPos;
      nxt_cfg.negSel    = pairNeg;
      nxt_cfg.negGnd    = 1'b0;
      nxt_cfg.addrLegal = pendDiffLegal;
    end
    // twos complement unless single span with SE or pseudo inputs
    if (!pend_ff.range && nxt_cfg.inType != aicl_pkg::AICL_IN_FULLDIFF)
      nxt_cfg.coding = aicl_pkg::AICL_CODE_BINARY;
    else
      nxt_cfg.coding = aicl_pkg::AICL_CODE_TWOS;
  end

  // previous synchronised select level, for edge detection; resets to the idle level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      csPrev_ff <= 1'b0;
    end
    else
    begin
      csPrev_ff <= csSync;
    end
  end

  // one-cycle start pulse per detected falling edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= csFall;
    end
  end

  // step divisor reads zero from reset until the first clk edge after release
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lsb_ff <= '0;
    end
    else
    begin
      lsb_ff <= (RESOLUTION+1)'(aicl_pkg::LSB_DIVISOR);
    end
  end

  // this conversion uses what the previous edge latched
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      act_ff <= '0;
    end
    else if (csFall)
    begin
      act_ff <= nxt_cfg;
    end
  end

  // pins taken at this edge wait for the next conversion
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_ff <= '0;
    end
    else if (csFall)
    begin
      pend_ff <= pinsSync;
    end
  end

  // conversion window from select fall to select rise
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_ff <= 1'b0;
    end
    else if (csFall)
    begin
      active_ff <= 1'b1;
    end
    else if (csRise)
    begin
      active_ff <= 1'b0;
    end
  end

  assign convStart   = start_ff;
  assign convActive  = active_ff;
  assign activeCfg   = act_ff;
  assign pendingPins = pend_ff;
  assign lsbDivisor  = lsb_ff;
endmodule

// ### aicl_monitor.sv
/* aicl_monitor: port assertions of the config latch.
   Assumes one clk domain, sys_rst async high. */
`timescale 1ns/1ps
module aicl_monitor #(
  parameter int unsigned RESOLUTION = 12
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // host pins
  input wire logic                 chipSelect_n,
  input wire logic                 input_type_select,
  input wire logic                 chan_addr_bit0,
  input wire logic                 chan_addr_bit1,
  input wire logic                 chan_addr_bit2,
  input wire logic                 rangeSelect,
  // results
  input wire logic                 convStart,
  input wire logic                 convActive,
  input wire aicl_pkg::aicl_cfg_t  activeCfg,
  input wire aicl_pkg::aicl_pins_t pendingPins,
  input wire logic [RESOLUTION:0]  lsbDivisor
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_lat; $fell(chipSelect_n) |-> ##[2:5] convStart; endproperty
  a_lat: assert property (p_lat) else $error("no start");
  property p_pul; convStart |=> !convStart; endproperty
  a_pul: assert property (p_pul) else $error("long start");
  property p_act; convStart |-> convActive; endproperty
  a_act: assert property (p_act) else $error("start without active");
  property p_pend; convStart |-> pendingPins == {input_type_select,
    chan_addr_bit2, chan_addr_bit1, chan_addr_bit0, rangeSelect}; endproperty
  a_pend: assert property (p_pend) else $error("bad pending");
  property p_hold; !convStart |-> $stable(activeCfg) && $stable(pendingPins); endproperty
  a_hold: assert property (p_hold) else $error("cfg moved");
  property p_rng; convStart |-> activeCfg.rangeDouble == $past(pendingPins.range); endproperty
  a_rng: assert property (p_rng) else $error("bad range");
  property p_cod; activeCfg.coding == ((activeCfg.rangeDouble || activeCfg.inType ==
    aicl_pkg::AICL_IN_FULLDIFF) ? aicl_pkg::AICL_CODE_TWOS : aicl_pkg::AICL_CODE_BINARY);
  endproperty
  a_cod: assert property (p_cod) else $error("bad coding");
  property p_dif; activeCfg.inType != aicl_pkg::AICL_IN_SINGLE |->
    !activeCfg.negGnd && activeCfg.negSel == activeCfg.posSel << 1; endproperty
  a_dif: assert property (p_dif) else $error("bad pair");
  property p_lsb; !$past(sys_rst) |-> lsbDivisor == 13'h1000; endproperty
  a_lsb: assert property (p_lsb) else $error("bad step");
endmodule
bind aicl_adc_input_config_latch aicl_monitor #(.RESOLUTION(RESOLUTION)) u_aicl_monitor (
  .clk(clk), .sys_rst(sys_rst), .chipSelect_n(chipSelect_n),
  .input_type_select(input_type_select), .chan_addr_bit0(chan_addr_bit0),
  .chan_addr_bit1(chan_addr_bit1), .chan_addr_bit2(chan_addr_bit2),
  .rangeSelect(rangeSelect), .convStart(convStart), .convActive(convActive),
  .activeCfg(activeCfg), .pendingPins(pendingPins), .lsbDivisor(lsbDivisor));

// ### aicl_host_model.sv
/* aicl_host_model: host driving select and config pins.
   Assumes one caller of convert at a time. */
`timescale 1ns/1ps
module aicl_host_model (
  // clock
  input wire logic             clk,
  // pins
  output logic                 selN,
  output aicl_pkg::aicl_pins_t pins
);
  initial
  begin
    selN = 1'h1;
    pins = '0;
  end
  // pins held only 3+ clk around the fall, then turned over so a late sample shows
  task automatic convert(input aicl_pkg::aicl_pins_t p, input int lowCyc);
    pins <= p;
    repeat (3) @(posedge clk);
    selN <= 1'h0;
    repeat (6) @(posedge clk);
    pins <= ~p;
    repeat (lowCyc) @(posedge clk);
    selN <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### aicl_adc_input_config_latch_tb.sv
/* aicl_adc_input_config_latch_tb: table and random conversions.
   Assumes the host model paces the pins. */
`timescale 1ns/1ps
module aicl_adc_input_config_latch_tb;
  logic                 clk;
  logic                 sys_rst;
  logic                 selN;
  logic                 convStart;
  logic                 convActive;
  logic [12:0]          lsbDivisor;
  logic                 chkIdle = 1'b0;
  aicl_pkg::aicl_pins_t pins;
  aicl_pkg::aicl_pins_t prevPins;
  aicl_pkg::aicl_pins_t curPins;
  aicl_pkg::aicl_pins_t pendingPins;
  aicl_pkg::aicl_cfg_t  activeCfg;
  int                   fail_count = 0;
  int                   n_tests = 0;
  int                   cyc = 0;
  logic [31:0]          seed = 32'h00007D58;
  aicl_host_model u_aicl_host_model (.clk(clk), .selN(selN), .pins(pins));
  aicl_adc_input_config_latch #(.RESOLUTION(12)) u_aicl_adc_input_config_latch (
    .clk(clk), .sys_rst(sys_rst), .chipSelect_n(selN), .input_type_select(pins.sgl),
    .chan_addr_bit0(pins.addr[0]), .chan_addr_bit1(pins.addr[1]),
    .chan_addr_bit2(pins.addr[2]), .rangeSelect(pins.range), .convStart(convStart),
    .convActive(convActive), .activeCfg(activeCfg), .pendingPins(pendingPins),
    .lsbDivisor(lsbDivisor));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic aicl_pkg::aicl_cfg_t expCfg(aicl_pkg::aicl_pins_t p);
    aicl_pkg::aicl_cfg_t c;
    logic legal;
    c = '0;
    legal = p.sgl ? (p.addr <= aicl_pkg::ADDR_MAX_SGL) : (p.addr[2:1] <= aicl_pkg::PAIR_MAX);
    c.addrLegal = legal;
    c.rangeDouble = p.range;
    c.negGnd = p.sgl;
    c.posSel = legal ? 6'h01 << (p.sgl ? p.addr : {p.addr[2:1], 1'h0}) : 6'h00;
    c.negSel = p.sgl ? 6'h00 : c.posSel << 1;
    c.inType = p.sgl ? aicl_pkg::AICL_IN_SINGLE
      : (p.addr[0] ? aicl_pkg::AICL_IN_PSEUDODIFF : aicl_pkg::AICL_IN_FULLDIFF);
    c.coding = (p.range || c.inType == aicl_pkg::AICL_IN_FULLDIFF)
      ? aicl_pkg::AICL_CODE_TWOS : aicl_pkg::AICL_CODE_BINARY;
    return c;
  endfunction
  task automatic cmpCfg(aicl_pkg::aicl_cfg_t g, aicl_pkg::aicl_cfg_t e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t cfg %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmpPins(aicl_pkg::aicl_pins_t g, aicl_pkg::aicl_pins_t e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t pins %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmpVal(logic [12:0] g, logic [12:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t val %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(aicl_pkg::aicl_pins_t p);
    curPins = p;
    u_aicl_host_model.convert(p, int'(rnd() % 4));
    chkIdle = 1'b1;
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (convStart === 1'b1)
    begin
      cmpCfg(activeCfg, expCfg(prevPins));
      cmpPins(pendingPins, curPins);
      cmpVal({12'h000, convActive}, 13'h0001);
      cmpVal(lsbDivisor, 13'(aicl_pkg::LSB_DIVISOR));
      prevPins = curPins;
    end
    if (chkIdle)
    begin
      cmpVal({12'h000, convActive}, 13'h0000);
      chkIdle = 1'b0;
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    sys_rst = 1'h1;
    prevPins = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 32; i++)
      run(5'(i));
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    prevPins = '0;
    repeat (3) @(posedge clk);
    repeat (40)
      run(rnd() % 2 ? {1'h1, 3'(rnd() % 6), 1'(rnd())} : {1'h0, 2'(rnd() % 3), 2'(rnd())});
    end_of_test();
  end
endmodule
